// [common/tcsw_pkg.sv]
// Constants and types shared by the two-channel switch controller
package tcsw_pkg;

  // Clock period of clk_i
  localparam int CLK_PERIOD_NS = 50;

  // Interrupt pulse minimums, in ns as printed
  localparam int IRQ_LOW_PULSE_MIN_NS = 1000;
  localparam int IRQ_HIGH_PULSE_MIN_NS = 500;
  // Interrupt output deadlines, in ns
  localparam int IRQ_ASSERT_DELAY_NS = 4000;
  localparam int IRQ_RELEASE_DELAY_NS = 2000;

  // Least times round up to whole cycles
  localparam int IRQ_LOW_CYC_I =
    (IRQ_LOW_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRQ_HIGH_CYC_I =
    (IRQ_HIGH_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W = 5;
  localparam logic [FILT_W-1:0] IRQ_LOW_CYC = FILT_W'(IRQ_LOW_CYC_I);
  localparam logic [FILT_W-1:0] IRQ_HIGH_CYC = FILT_W'(IRQ_HIGH_CYC_I);

  // Reset pin timing, in ns (met by the asynchronous reset path)
  localparam int RESET_LOW_MIN_WIDTH_NS = 4;
  localparam int RESET_SDA_CLEAR_MAX_NS = 500;
  localparam int RESET_TO_START_RECOVERY_NS = 0;

  // Fixed upper part of the slave address (arbitrary value)
  localparam logic [4:0] ADDR_FIXED = 5'h15;

  // Control byte layout
  localparam int CH0_BIT = 0;
  localparam int CH1_BIT = 1;
  localparam int IRQ0_BIT = 4;
  localparam int IRQ1_BIT = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Serial framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // Serial state machine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_WRITE,
    ST_WACK,
    ST_READ,
    ST_RACK
  } tcsw_state_e;

endpackage

// [core/tcsw_ctrl.sv]
// Serial slave, control byte and interrupt logic of the switch
`timescale 1ns/10ps

module tcsw_ctrl (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ext_reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_sel_bit0_i,
  input wire logic addr_sel_bit1_i,
  input wire logic chan0_irq_in_n_i,
  input wire logic chan1_irq_in_n_i,
  output logic irq_n_o,
  output logic [1:0] chan_en_o
);

  // Combined reset: power-on and pin, both asynchronous
  logic arst_n; // Low while either reset is active
  assign arst_n = rstn_i & ext_reset_n_i;

  // Synchroniser stages for bus lines
  logic scl_meta; // First stage, read only by scl_sync
  logic scl_sync; // Second stage
  logic scl_prev; // Previous synced clock
  logic sda_meta; // First stage, read only by sda_sync
  logic sda_sync; // Second stage
  logic sda_prev; // Previous synced data

  // Synchroniser stages for address pins and irq inputs
  logic [3:0] pin_meta; // First stages
  logic [3:0] pin_sync; // Second stages

  // Filtered interrupt state, one per channel (1 = active)
  localparam int FILT_W_L = tcsw_pkg::FILT_W;
  logic [1:0] irq_act;
  logic [FILT_W_L-1:0] filt_cnt [2];

  // Serial machine state
  tcsw_pkg::tcsw_state_e state; // Current state
  logic [3:0] bit_cnt; // Bits of current byte
  logic [7:0] rx_shift; // Received bits
  logic [7:0] tx_shift; // Bits to send
  logic rd_mode; // Transfer is a read
  logic mst_ack; // Master acked last read byte

  // Control register content
  logic [1:0] chan_pend; // Selection awaiting stop
  logic [1:0] irq_stat; // Status loaded at read
  logic [7:0] rd_view; // Byte sent again after a master ack

  // Decoded bus events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_hit;

  // Read view of the control byte
  function automatic logic [7:0] ctrl_view(
    input logic [1:0] chan,
    input logic [1:0] irq
  );
    logic [7:0] v;
    v = tcsw_pkg::CTRL_RESET;
    v[tcsw_pkg::CH0_BIT] = chan[0];
    v[tcsw_pkg::CH1_BIT] = chan[1];
    v[tcsw_pkg::IRQ0_BIT] = irq[0];
    v[tcsw_pkg::IRQ1_BIT] = irq[1];
    return v;
  endfunction
  // Repeated read byte keeps the latched status
  assign rd_view = ctrl_view(chan_pend, irq_stat);

  // Bus line synchronisers; reset to idle high
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  // Pin synchronisers; irq inputs idle high
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta <= 4'hc;
      pin_sync <= 4'hc;
    end else begin
      pin_meta <= {chan1_irq_in_n_i, chan0_irq_in_n_i,
                   addr_sel_bit1_i, addr_sel_bit0_i};
      pin_sync <= pin_meta;
    end
  end

  // Edge and condition decode from synced lines
  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  // Data change while clock stays high
  assign start_det = scl_sync & scl_prev &
                     sda_prev & ~sda_sync;
  assign stop_det = scl_sync & scl_prev &
                    ~sda_prev & sda_sync;
  // Fixed part plus two select pins
  assign addr_hit =
    (rx_shift[7:1] == {tcsw_pkg::ADDR_FIXED, pin_sync[1:0]});

  // Glitch filters: level flips only after a full minimum
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic raw_act; // Input asks for active (low)
    logic [FILT_W_L-1:0] need; // Cycles needed to flip
    assign raw_act = ~pin_sync[2 + g];
    assign need = irq_act[g] ? tcsw_pkg::IRQ_HIGH_CYC
                             : tcsw_pkg::IRQ_LOW_CYC;
    always_ff @(posedge clk_i or negedge arst_n) begin
      if (!arst_n) begin
        irq_act[g] <= 1'b0;
        filt_cnt[g] <= '0;
      end else if (raw_act == irq_act[g]) begin
        // Short pulse ended: discard it
        filt_cnt[g] <= '0;
      end else if (filt_cnt[g] == need - FILT_W_L'(1)) begin
        // Held long enough: accept new level
        irq_act[g] <= raw_act;
        filt_cnt[g] <= '0;
      end else begin
        filt_cnt[g] <= filt_cnt[g] + FILT_W_L'(1);
      end
    end
  end

  // Combined interrupt output, low while any channel active
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= ~(irq_act[0] | irq_act[1]);
    end
  end

  // Open-drain data value is always low; oe pulls the line
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // Serial slave state machine
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      // Reset releases the data line at once
      state <= tcsw_pkg::ST_IDLE;
      sda_oe_o <= 1'b0;
      bit_cnt <= tcsw_pkg::CNT_ZERO;
      rx_shift <= tcsw_pkg::CTRL_RESET;
      tx_shift <= tcsw_pkg::CTRL_RESET;
      rd_mode <= 1'b0;
      mst_ack <= 1'b0;
    end else if (start_det) begin
      // Start or repeated start from any state
      state <= tcsw_pkg::ST_ADDR;
      sda_oe_o <= 1'b0;
      bit_cnt <= tcsw_pkg::CNT_ZERO;
    end else if (stop_det) begin
      // Stop ends any transfer
      state <= tcsw_pkg::ST_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        tcsw_pkg::ST_IDLE: begin
          // Wait for a start
          sda_oe_o <= 1'b0;
        end
        tcsw_pkg::ST_ADDR: begin
          if (scl_rise) begin
            // Sample address bit
            rx_shift <= {rx_shift[6:0], sda_sync};
            bit_cnt <= bit_cnt + tcsw_pkg::CNT_ONE;
          end else if (scl_fall &&
                       bit_cnt == tcsw_pkg::BYTE_BITS) begin
            if (addr_hit) begin
              // Own address: acknowledge
              state <= tcsw_pkg::ST_AACK;
              sda_oe_o <= 1'b1;
              rd_mode <= rx_shift[0];
              tx_shift <= ctrl_view(chan_pend, irq_act);
            end else begin
              // Other slave: stay off the bus
              state <= tcsw_pkg::ST_IDLE;
            end
          end
        end
        tcsw_pkg::ST_AACK: begin
          if (scl_fall) begin
            bit_cnt <= tcsw_pkg::CNT_ZERO;
            if (rd_mode) begin
              // Drive first read bit
              state <= tcsw_pkg::ST_READ;
              sda_oe_o <= ~tx_shift[7];
            end else begin
              // Release for master data
              state <= tcsw_pkg::ST_WRITE;
              sda_oe_o <= 1'b0;
            end
          end
        end
        tcsw_pkg::ST_WRITE: begin
          if (scl_rise) begin
            // Sample data bit
            rx_shift <= {rx_shift[6:0], sda_sync};
            bit_cnt <= bit_cnt + tcsw_pkg::CNT_ONE;
          end else if (scl_fall &&
                       bit_cnt == tcsw_pkg::BYTE_BITS) begin
            // Acknowledge each data byte
            state <= tcsw_pkg::ST_WACK;
            sda_oe_o <= 1'b1;
          end
        end
        tcsw_pkg::ST_WACK: begin
          if (scl_fall) begin
            // Ready for a further byte
            state <= tcsw_pkg::ST_WRITE;
            sda_oe_o <= 1'b0;
            bit_cnt <= tcsw_pkg::CNT_ZERO;
          end
        end
        tcsw_pkg::ST_READ: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + tcsw_pkg::CNT_ONE;
          end else if (scl_fall) begin
            if (bit_cnt == tcsw_pkg::BYTE_BITS) begin
              // Release for master ack bit
              state <= tcsw_pkg::ST_RACK;
              sda_oe_o <= 1'b0;
            end else begin
              // Next bit, changed only with clock low
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_oe_o <= ~tx_shift[6];
            end
          end
        end
        tcsw_pkg::ST_RACK: begin
          if (scl_rise) begin
            // Low means master wants more
            mst_ack <= ~sda_sync;
          end else if (scl_fall) begin
            if (mst_ack) begin
              // Send the byte again
              state <= tcsw_pkg::ST_READ;
              tx_shift <= rd_view;
              sda_oe_o <= ~rd_view[7];
              bit_cnt <= tcsw_pkg::CNT_ZERO;
            end else begin
              // Nack: stay released until stop
              state <= tcsw_pkg::ST_IDLE;
              sda_oe_o <= 1'b0;
            end
          end
        end
        default: begin
          state <= tcsw_pkg::ST_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Pending selection: last written byte wins
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      chan_pend <= tcsw_pkg::CTRL_RESET[1:0];
    end else if (state == tcsw_pkg::ST_WRITE && scl_fall &&
                 bit_cnt == tcsw_pkg::BYTE_BITS &&
                 !start_det && !stop_det) begin
      chan_pend <= {rx_shift[tcsw_pkg::CH1_BIT],
                    rx_shift[tcsw_pkg::CH0_BIT]};
    end
  end

  // Interrupt status, loaded when a read is addressed
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat <= tcsw_pkg::CTRL_RESET[1:0];
    end else if (state == tcsw_pkg::ST_ADDR && scl_fall &&
                 bit_cnt == tcsw_pkg::BYTE_BITS && addr_hit &&
                 rx_shift[0] && !start_det && !stop_det) begin
      irq_stat <= irq_act;
    end
  end

  // Active channels follow the pending byte at stop
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      chan_en_o <= 2'h0;
    end else if (stop_det) begin
      chan_en_o <= chan_pend;
    end
  end

endmodule

// [test/tcsw_ctrl_monitor.sv]
// Port checker for the switch controller
`timescale 1ns/10ps
module tcsw_ctrl_monitor (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ext_reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic addr_sel_bit0_i,
  input wire logic addr_sel_bit1_i,
  input wire logic chan0_irq_in_n_i,
  input wire logic chan1_irq_in_n_i,
  input wire logic irq_n_o,
  input wire logic [1:0] chan_en_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [7:0] lo_cnt; // Cycles some request input is low
  logic [7:0] hi_cnt; // Cycles both request inputs are high
  wire logic any_lo = !chan0_irq_in_n_i || !chan1_irq_in_n_i;
  // Low run counter, cleared by the reset pin
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) lo_cnt <= 8'h00;
    else if (!ext_reset_n_i || !any_lo) lo_cnt <= 8'h00;
    else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
  end
  // High run counter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) hi_cnt <= 8'h00;
    else if (!ext_reset_n_i || any_lo) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
  end
  property p_sda_const; sda_o == 1'b0; endproperty
  a_sda_const: assert property (p_sda_const)
    else $error("data output not low");
  property p_rst; !ext_reset_n_i |-> !sda_oe_o && chan_en_o == 2'h0
    && irq_n_o; endproperty
  a_rst: assert property (p_rst)
    else $error("reset pin did not clear outputs");
  property p_chan_stop; disable iff (!rstn_i || !ext_reset_n_i)
    $changed(chan_en_o) |-> scl_i && sda_i && $past(scl_i, 3); endproperty
  a_chan_stop: assert property (p_chan_stop)
    else $error("channels changed outside a stop");
  property p_oe_scl; disable iff (!rstn_i || !ext_reset_n_i)
    $changed(sda_oe_o) |-> !scl_i && !$past(scl_i); endproperty
  a_oe_scl: assert property (p_oe_scl)
    else $error("data line changed while clock high");
  property p_irq_slow; disable iff (!rstn_i || !ext_reset_n_i)
    $fell(irq_n_o) |-> lo_cnt >= 8'h14; endproperty
  a_irq_slow: assert property (p_irq_slow)
    else $error("irq asserted on a short low pulse");
  property p_irq_fast; lo_cnt == 8'h50 |-> !irq_n_o; endproperty
  a_irq_fast: assert property (p_irq_fast)
    else $error("irq not asserted in time");
  property p_irq_hi_slow; disable iff (!rstn_i || !ext_reset_n_i)
    $rose(irq_n_o) |-> hi_cnt >= 8'h0a; endproperty
  a_irq_hi_slow: assert property (p_irq_hi_slow)
    else $error("irq released on a short high pulse");
  property p_irq_rel; hi_cnt == 8'h28 |-> irq_n_o; endproperty
  a_irq_rel: assert property (p_irq_rel)
    else $error("irq not released in time");
endmodule
bind tcsw_ctrl tcsw_ctrl_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i),
  .ext_reset_n_i(ext_reset_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_sel_bit0_i(addr_sel_bit0_i),
  .addr_sel_bit1_i(addr_sel_bit1_i), .chan0_irq_in_n_i(chan0_irq_in_n_i),
  .chan1_irq_in_n_i(chan1_irq_in_n_i), .irq_n_o(irq_n_o),
  .chan_en_o(chan_en_o));

// [test/tcsw_master.sv]
// Serial bus master model on the upstream pair
`timescale 1ns/10ps
module tcsw_master (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  // Both lines released while the bus is idle
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Start or repeated start
  task automatic start();
    sda_o = 1'b1;
    #100 scl_o = 1'b1;
    #200 sda_o = 1'b0;
    #200 scl_o = 1'b0;
  endtask
  // Stop, clock then left high
  task automatic stop();
    #150 sda_o = 1'b0;
    #100 scl_o = 1'b1;
    #200 sda_o = 1'b1;
    #200;
  endtask
  // One bit: data set in clock low, sampled late in clock high
  task automatic bit_io(input logic b, output logic s);
    #150 sda_o = b;
    #100 scl_o = 1'b1;
    #140 s = sda_i;
    #10 scl_o = 1'b0;
  endtask
  // Byte out MSB first, then line released for the ack
  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, ack_n);
  endtask
  // Byte in MSB first, then ack or withheld ack
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule

// [test/tcsw_ctrl_tb.sv]
// Testbench for the switch controller
`timescale 1ns/10ps
module tcsw_ctrl_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0; // Power-on reset, active low
  logic ext_rstn = 1'b1; // Reset pin, active low
  logic [1:0] asel = 2'h2; // Address select pins
  logic irq0_n = 1'b1;
  logic irq1_n = 1'b1;
  logic scl, sda_m, sda_d, sda_oe, irq_n;
  logic [1:0] chan;
  int bad_count = 0;
  int check_count = 0;
  // Open-drain data wire with pull-up
  wire logic sda_w = sda_m & ~(sda_oe & ~sda_d);
  always #25 clk = ~clk;
  tcsw_master u_mst (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));
  tcsw_ctrl u_dut (.clk_i(clk), .rstn_i(rstn), .ext_reset_n_i(ext_rstn),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe),
    .addr_sel_bit0_i(asel[0]), .addr_sel_bit1_i(asel[1]),
    .chan0_irq_in_n_i(irq0_n), .chan1_irq_in_n_i(irq1_n),
    .irq_n_o(irq_n), .chan_en_o(chan));
  // Compare and count
  task automatic chk(input string what, input logic [7:0] e,
    input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // Wait cycles, then step past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Start and address byte
  task automatic addr(input logic [1:0] sel, input logic rw,
    input logic ea);
    logic a;
    u_mst.start();
    u_mst.wbyte({tcsw_pkg::ADDR_FIXED, sel, rw}, a);
    chk("addr ack", {7'h00, ea}, {7'h00, a});
  endtask
  // Data byte, optional stop
  task automatic reg_wr(input logic [7:0] d, input logic last);
    logic a;
    u_mst.wbyte(d, a);
    chk("data ack", 8'h00, {7'h00, a});
    if (last) u_mst.stop();
    tick(2);
  endtask
  // Whole read: first byte acked, repeat not acked
  task automatic reg_rd(input logic [7:0] e);
    logic [7:0] b;
    logic [7:0] b2;
    addr(2'h2, 1'b1, 1'b0);
    u_mst.rbyte(1'b0, b);
    u_mst.rbyte(1'b1, b2);
    u_mst.stop();
    chk("read byte", e, b);
    chk("read again", e, b2);
  endtask
  // Several bytes, only last kept, applied at stop
  task automatic t_write();
    addr(2'h2, 1'b0, 1'b0);
    reg_wr(8'h02, 1'b0);
    reg_wr(8'hfd, 1'b0);
    chk("chan before stop", 8'h00, {6'h00, chan});
    u_mst.stop();
    tick(2);
    chk("chan after stop", 8'h01, {6'h00, chan});
    reg_rd(8'h01);
    $display("test write done");
  endtask
  // Every channel combination
  task automatic t_codes();
    for (int c = 0; c < 4; c++) begin
      addr(2'h2, 1'b0, 1'b0);
      reg_wr(8'(c), 1'b1);
      chk("chan code", 8'(c), {6'h00, chan});
      reg_rd(8'(c));
    end
    $display("test codes done");
  endtask
  // Address select pins
  task automatic t_addr();
    asel = 2'h1;
    tick(4);
    addr(2'h2, 1'b0, 1'b1);
    u_mst.stop();
    tick(2);
    chk("chan unaddressed", 8'h03, {6'h00, chan});
    addr(2'h1, 1'b0, 1'b0);
    reg_wr(8'h00, 1'b1);
    chk("chan new pins", 8'h00, {6'h00, chan});
    asel = 2'h2;
    tick(4);
    $display("test address done");
  endtask
  // Interrupt filter, delays and status
  task automatic t_irq();
    irq0_n = 1'b0;
    tick(15);
    irq0_n = 1'b1;
    tick(80);
    chk("irq short low", 8'h01, {7'h00, irq_n});
    reg_rd(8'h00);
    irq1_n = 1'b0;
    tick(80);
    chk("irq on chan1", 8'h00, {7'h00, irq_n});
    reg_rd(8'h20);
    irq1_n = 1'b1;
    tick(8);
    irq1_n = 1'b0;
    tick(40);
    chk("irq short high", 8'h00, {7'h00, irq_n});
    irq0_n = 1'b0;
    tick(40);
    irq1_n = 1'b1;
    tick(80);
    chk("irq on chan0", 8'h00, {7'h00, irq_n});
    reg_rd(8'h10);
    irq0_n = 1'b1;
    tick(40);
    chk("irq released", 8'h01, {7'h00, irq_n});
    reg_rd(8'h00);
    $display("test irq done");
  endtask
  // Reset pin mid-read, then an immediate start
  task automatic t_reset();
    logic s;
    addr(2'h2, 1'b0, 1'b0);
    reg_wr(8'h03, 1'b1);
    addr(2'h2, 1'b1, 1'b0);
    u_mst.bit_io(1'b1, s);
    chk("driving bit", 8'h01, {7'h00, sda_oe});
    ext_rstn = 1'b0;
    tick(1);
    chk("oe in reset", 8'h00, {7'h00, sda_oe});
    chk("chan in reset", 8'h00, {6'h00, chan});
    ext_rstn = 1'b1;
    addr(2'h2, 1'b0, 1'b0);
    reg_wr(8'h02, 1'b1);
    chk("chan after reset", 8'h02, {6'h00, chan});
    $display("test reset done");
  endtask
  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    tick(3);
    chk("chan at power-on", 8'h00, {6'h00, chan});
    chk("irq at power-on", 8'h01, {7'h00, irq_n});
    rstn = 1'b1;
    tick(1);
    t_write();
    t_codes();
    t_addr();
    t_irq();
    t_reset();
    end_of_test();
  end
endmodule
